// file: core/tw_consts.svh
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH

// register offsets
`define TW_ADDR_COMM 5'h00
`define TW_ADDR_DCLK 5'h01
`define TW_ADDR_VCO_DRV 5'h08
`define TW_ADDR_BIAS 5'h09
`define TW_ADDR_LOOP 5'h0A
`define TW_ADDR_REV 5'h1F
`define TW_ADDR_TOP 5'h1F
`define TW_ADDR_BOT 5'h00

// reset values and fixed codes
`define TW_RST_VAL 8'h00
// arbitrary revision value
`define TW_REV_CODE 8'h5A

// port control register bits
`define TW_BIT_BIDIR 7
`define TW_BIT_LSB 6
`define TW_BIT_SRST 5
`define TW_BIT_PD 4
`define TW_BIT_APD 3
`define TW_BIT_LOCK 1

// other fields
`define TW_BIT_DLY_MSB 1
`define TW_INS_RW 7
`define TW_INS_CNT_HI 6
`define TW_INS_CNT_LO 5
`define TW_INS_ADDR_HI 4
`define TW_LOOP_BW_HI 4
`define TW_VCO_CTL_HI 7
`define TW_VCO_CTL_LO 5
`define TW_BIAS_HI 2
`define TW_VCO_DRV_HI 1

// bit count of a byte, last index
`define TW_LAST_BIT 3'h7

`endif

// file: core/tw_pkg.sv
package tw_pkg;

    typedef logic [7:0] tw_byte_t;
    typedef logic [4:0] tw_addr_t;

    // gray along instruction -> data -> done
    typedef enum logic [1:0] {
        TW_INSTR = 2'h0,
        TW_DATA = 2'h1,
        TW_DONE = 2'h3
    } tw_state_e;

    typedef struct packed {
        logic sdio_bidir;
        logic lsb_first;
        logic soft_reset;
        logic power_down;
        logic auto_pd;
        logic delay_msb;
        logic [4:0] loop_bw;
        logic [2:0] pll_bias;
        logic [2:0] vco_ctrl;
        logic [1:0] vco_drive;
    } tw_cfg_s;

endpackage : tw_pkg

// file: core/tw_port.sv
`timescale 1ns/10ps
`include "tw_consts.svh"

module tw_port (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic port_select_n,
    input wire logic sdio_in,
    input wire logic pll_locked,
    output logic sdio_out,
    output logic sdio_oe_n,
    output logic serial_out_pin,
    output logic serial_out_oe_n,
    output tw_pkg::tw_cfg_s cfg
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic tw_pkg::tw_byte_t assemble(
        input tw_pkg::tw_byte_t sh,
        input logic din,
        input logic lsb
    );
        if (lsb) begin
            assemble = {din, sh[7:1]};
        end else begin
            assemble = {sh[6:0], din};
        end
    endfunction : assemble

    // saturates at either end rather than wrapping
    function automatic tw_pkg::tw_addr_t step_addr(
        input tw_pkg::tw_addr_t a,
        input logic lsb
    );
        if (lsb) begin
            step_addr = (a == `TW_ADDR_TOP) ? a : 5'(a + 5'h01);
        end else begin
            step_addr = (a == `TW_ADDR_BOT) ? a : 5'(a - 5'h01);
        end
    endfunction : step_addr

    ////////////////////////////////////////////////////////////////////////
    // link-domain declarations

    tw_pkg::tw_byte_t mem [0:31];
    tw_pkg::tw_state_e state;
    tw_pkg::tw_state_e next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    tw_pkg::tw_byte_t sh;
    tw_pkg::tw_byte_t next_sh;
    tw_pkg::tw_byte_t tx;
    tw_pkg::tw_byte_t next_tx;
    tw_pkg::tw_addr_t addr;
    tw_pkg::tw_addr_t next_addr;
    logic [1:0] left;
    logic [1:0] next_left;
    logic rd;
    logic next_rd;
    logic wr_en;
    tw_pkg::tw_byte_t byte_in;
    tw_pkg::tw_addr_t rd_addr;
    tw_pkg::tw_byte_t rd_data;
    logic lsb_cur;
    logic lsb_new;
    logic bidir;
    logic ctl_rst_n;
    logic lock_s1;
    logic lock_s2;
    logic wr_tog;
    logic next_wr_tog;
    logic out_bit;
    logic next_out_bit;
    logic drive_sdio;
    logic next_drive_sdio;
    logic drive_sdo;
    logic next_drive_sdo;

    // chip select high holds the controller in its start state
    assign ctl_rst_n = nrst & ~port_select_n;

    assign lsb_cur = mem[`TW_ADDR_COMM][`TW_BIT_LSB];
    assign bidir = mem[`TW_ADDR_COMM][`TW_BIT_BIDIR];
    assign byte_in = assemble(sh, sdio_in, lsb_cur);

    // a write to the control byte changes the order for what follows
    assign lsb_new = (wr_en && addr == `TW_ADDR_COMM) ? byte_in[`TW_BIT_LSB] : lsb_cur;

    ////////////////////////////////////////////////////////////////////////
    // read mux

    always_comb begin
        if (state == tw_pkg::TW_INSTR) begin
            rd_addr = byte_in[`TW_INS_ADDR_HI:0];
        end else begin
            rd_addr = step_addr(addr, lsb_new);
        end
        if (rd_addr == `TW_ADDR_REV) begin
            rd_data = `TW_REV_CODE;
        end else if (rd_addr == `TW_ADDR_COMM) begin
            rd_data = mem[`TW_ADDR_COMM];
            rd_data[`TW_BIT_LOCK] = lock_s2;
        end else begin
            rd_data = mem[rd_addr];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer controller

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_tx = tx;
        next_addr = addr;
        next_left = left;
        next_rd = rd;
        wr_en = 1'b0;
        unique case (state)
            tw_pkg::TW_INSTR: begin
                next_cnt = 3'(cnt + 3'h1);
                next_sh = byte_in;
                if (cnt == `TW_LAST_BIT) begin
                    next_rd = byte_in[`TW_INS_RW];
                    next_left = byte_in[`TW_INS_CNT_HI:`TW_INS_CNT_LO];
                    next_addr = byte_in[`TW_INS_ADDR_HI:0];
                    next_tx = rd_data;
                    next_state = tw_pkg::TW_DATA;
                end
            end
            tw_pkg::TW_DATA: begin
                next_cnt = 3'(cnt + 3'h1);
                next_sh = byte_in;
                if (cnt == `TW_LAST_BIT) begin
                    wr_en = ~rd;
                    if (left == 2'h0) begin
                        next_state = tw_pkg::TW_DONE;
                    end else begin
                        next_left = 2'(left - 2'h1);
                        next_addr = step_addr(addr, lsb_new);
                        next_tx = rd_data;
                    end
                end
            end
            tw_pkg::TW_DONE: begin
                next_cnt = cnt;
            end
            default: begin
                next_state = tw_pkg::TW_DONE;
            end
        endcase
    end

    always_ff @(posedge sclk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            state <= tw_pkg::TW_INSTR;
            cnt <= 3'h0;
            sh <= 8'h00;
            tx <= 8'h00;
            addr <= 5'h00;
            left <= 2'h0;
            rd <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            tx <= next_tx;
            addr <= next_addr;
            left <= next_left;
            rd <= next_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file, written at the last bit of each data byte of a write transfer

    always_comb begin
        next_wr_tog = wr_tog ^ wr_en;
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 32; i++) begin
                mem[i] <= `TW_RST_VAL;
            end
            wr_tog <= 1'b0;
        end else begin
            // the revision slot is read-only
            if (wr_en && addr != `TW_ADDR_REV) begin
                mem[addr] <= byte_in;
            end
            wr_tog <= next_wr_tog;
        end
    end

    // lock status enters the link domain; only sampled while sclk runs
    // two flops, so the reported bit lags the pin by two serial clocks
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            lock_s1 <= pll_locked;
            lock_s2 <= lock_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data leaves on the falling edge

    always_comb begin
        next_out_bit = lsb_cur ? tx[cnt] : tx[3'(`TW_LAST_BIT - cnt)];
        next_drive_sdio = (state == tw_pkg::TW_DATA) && rd && bidir;
        next_drive_sdo = (state == tw_pkg::TW_DATA) && rd && !bidir;
    end

    always_ff @(negedge sclk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            out_bit <= 1'b0;
            drive_sdio <= 1'b0;
            drive_sdo <= 1'b0;
        end else begin
            out_bit <= next_out_bit;
            drive_sdio <= next_drive_sdio;
            drive_sdo <= next_drive_sdo;
        end
    end

    assign sdio_out = out_bit;
    assign serial_out_pin = out_bit;
    assign sdio_oe_n = ~drive_sdio;
    assign serial_out_oe_n = ~drive_sdo;

    ////////////////////////////////////////////////////////////////////////
    // system-domain copy of the settings

    tw_pkg::tw_cfg_s cfg_live;
    tw_pkg::tw_cfg_s next_cfg;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;

    // captured three clocks after each write toggle; a later byte of the
    // same transfer may still be landing then, but the capture after the
    // last byte sees settled registers, so only the final value counts
    always_comb begin
        cfg_live.sdio_bidir = mem[`TW_ADDR_COMM][`TW_BIT_BIDIR];
        cfg_live.lsb_first = mem[`TW_ADDR_COMM][`TW_BIT_LSB];
        cfg_live.soft_reset = mem[`TW_ADDR_COMM][`TW_BIT_SRST];
        cfg_live.power_down = mem[`TW_ADDR_COMM][`TW_BIT_PD];
        cfg_live.auto_pd = mem[`TW_ADDR_COMM][`TW_BIT_APD];
        cfg_live.delay_msb = mem[`TW_ADDR_DCLK][`TW_BIT_DLY_MSB];
        cfg_live.loop_bw = mem[`TW_ADDR_LOOP][`TW_LOOP_BW_HI:0];
        cfg_live.pll_bias = mem[`TW_ADDR_BIAS][`TW_BIAS_HI:0];
        cfg_live.vco_ctrl = mem[`TW_ADDR_LOOP][`TW_VCO_CTL_HI:`TW_VCO_CTL_LO];
        cfg_live.vco_drive = mem[`TW_ADDR_VCO_DRV][`TW_VCO_DRV_HI:0];
    end

    always_comb begin
        next_cfg = cfg;
        if (tog_s2 != tog_s3) begin
            next_cfg = cfg_live;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            cfg <= '0;
        end else begin
            tog_s1 <= wr_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            cfg <= next_cfg;
        end
    end

endmodule : tw_port

// file: tb/tw_host_model.sv
`timescale 1ns/10ps
module tw_host_model (
    output logic sclk,
    output logic port_select_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe_n
);
    logic hb = 1'h0;
    logic hen = 1'h0;
    logic lsb = 1'h0;
    logic bidir = 1'h0;
    logic flip = 1'h0;
    int cut = 0;
    int nb;
    // no pull on the line: released, it shows the inverse of the last bit
    assign sdio_in = !sdio_oe_n ? sdio_out : (hen ? hb : !hb);
    initial begin
        sclk = 1'h0;
        port_select_n = 1'h1;
    end
    ////////////////////////////////////////
    task automatic tick(input logic drv, input logic b, output logic r);
        if (cut == 0 || nb < cut) begin
            hen = drv;
            hb = drv ? b : hb;
            #6 sclk = 1'h1;
            r = bidir ? sdio_in : serial_out_pin;
            #6 sclk = 1'h0;
        end
        nb++;
    endtask : tick
    task automatic xfer(input logic rw, input logic [1:0] n, input logic [4:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        logic [7:0] ins;
        logic r;
        ins = {rw, n, a};
        rd = 32'h0;
        nb = 0;
        port_select_n = 1'h0;
        #6;
        for (int i = 0; i < 8; i++) tick(1'h1, ins[lsb ? i : 7 - i], r);
        for (int k = 0; k <= n; k++) begin
            for (int i = 0; i < 8; i++) begin
                tick(!rw, wd[8 * k + (lsb ? i : 7 - i)], r);
                rd[8 * k + (lsb ? i : 7 - i)] = r;
            end
            // order switched by the first byte: the rest follow the new order
            if (flip && k == 0) lsb = !lsb;
        end
        #6 port_select_n = 1'h1;
        hen = 1'h0;
        #12;
    endtask : xfer
endmodule : tw_host_model

// file: tb/tw_port_monitor.sv
`timescale 1ns/10ps
`include "tw_consts.svh"
module tw_port_mon (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic port_select_n,
    input wire logic sdio_in,
    input wire logic pll_locked,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe_n,
    input wire tw_pkg::tw_cfg_s cfg
);
    logic [5:0] cnt, next_cnt, last;
    logic [7:0] ins, next_ins, iw;
    logic [3:0] idle, next_idle;
    logic [2:0] idx;
    logic pin;
    wire [7:0] rev = `TW_REV_CODE;
    always_comb begin
        next_cnt = (cnt == 6'h3F) ? cnt : cnt + 6'h01;
        next_ins = (cnt < 6'h08) ? {ins[6:0], sdio_in} : ins;
        next_idle = !port_select_n ? 4'h0 : idle + {3'h0, idle != 4'hF};
        for (int i = 0; i < 8; i++) iw[i] = cfg.lsb_first ? ins[7 - i] : ins[i];
    end
    // cfg lags the port, so it is only trusted once settled between frames
    assign last = {1'h0, iw[6:5], 3'h0} + 6'h10;
    assign idx = cfg.lsb_first ? cnt[2:0] : ~cnt[2:0];
    assign pin = cfg.sdio_bidir ? sdio_out : serial_out_pin;
    always_ff @(posedge sclk or posedge port_select_n) begin
        if (port_select_n) begin
            cnt <= 6'h00;
            ins <= 8'h00;
        end else begin
            cnt <= next_cnt;
            ins <= next_ins;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idle <= 4'h0;
        end else begin
            idle <= next_idle;
        end
    end
    ////////////////////////////////////////
    sequence s_rd;
        cnt >= 6'h08 && cnt < last && iw[7];
    endsequence
    sequence s_rd0;
        s_rd ##0 cnt < 6'h10;
    endsequence
    property p_rd_drive;
        @(posedge sclk) disable iff (port_select_n) s_rd |-> !(cfg.sdio_bidir ? sdio_oe_n : serial_out_oe_n);
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read pin idle");
    property p_quiet;
        @(posedge sclk) disable iff (port_select_n) cnt < 6'h08 || !iw[7] |-> sdio_oe_n && serial_out_oe_n;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pin driven");
    property p_rev;
        @(posedge sclk) disable iff (port_select_n) s_rd0 ##0 iw[4:0] == 5'h1F |-> pin == rev[idx];
    endproperty
    a_rev: assert property (p_rev) else $error("rev bit");
    property p_lock;
        @(posedge sclk) disable iff (port_select_n) s_rd0 ##0 iw[4:0] == 5'h00 && idx == 3'h1 |-> pin == pll_locked;
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit");
    property p_float;
        @(posedge clk) disable iff (!nrst) port_select_n |-> sdio_oe_n && serial_out_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("not floating");
    property p_pin_sel;
        @(posedge clk) disable iff (!nrst)
            !(sdio_oe_n && serial_out_oe_n) |-> sdio_oe_n != serial_out_oe_n && sdio_oe_n != cfg.sdio_bidir;
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("wrong pin");
    property p_cfg_quiet;
        @(posedge clk) disable iff (!nrst) idle >= 4'h6 |-> $stable(cfg);
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("cfg moved");
    property p_rst;
        @(posedge clk) disable iff (!nrst) $rose(nrst) |-> cfg == '0 ##1 cfg == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("cfg not cleared");
endmodule : tw_port_mon
bind tw_port tw_port_mon u_mon (.clk(clk), .nrst(nrst), .sclk(sclk), .port_select_n(port_select_n),
    .sdio_in(sdio_in), .pll_locked(pll_locked), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n), .cfg(cfg));

// file: tb/tw_port_tb.sv
`timescale 1ns/10ps
`include "tw_consts.svh"
module tw_port_tb;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic pll_locked = 1'h0;
    wire sclk, port_select_n, sdio_in, sdio_out, sdio_oe_n, serial_out_pin, serial_out_oe_n;
    tw_pkg::tw_cfg_s cfg;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] rd;
    always #20 clk = ~clk;
    tw_port u_dut (.clk(clk), .nrst(nrst), .sclk(sclk), .port_select_n(port_select_n), .sdio_in(sdio_in),
        .pll_locked(pll_locked), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n), .cfg(cfg));
    tw_host_model u_host (.sclk(sclk), .port_select_n(port_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe_n(sdio_oe_n), .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n));
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [1:0] n, input logic [4:0] a, input logic [31:0] d);
        u_host.xfer(1'h0, n, a, d, rd);
        // cfg copy crosses into clk a few cycles late
        repeat (6) @(negedge clk);
    endtask : wr
    task automatic rdb(input logic [1:0] n, input logic [4:0] a);
        u_host.xfer(1'h1, n, a, 32'h0, rd);
    endtask : rdb
    task automatic t_main;
        chk("cfg", 32'h0, 32'(cfg));
        chk("oe_n", 32'h3, 32'({sdio_oe_n, serial_out_oe_n}));
        rdb(2'h0, `TW_ADDR_COMM);
        chk("comm", 32'h0, rd);
        @(negedge clk);
        pll_locked = 1'h1;
        rdb(2'h0, `TW_ADDR_COMM);
        chk("lock", 32'h2, rd);
        rdb(2'h0, `TW_ADDR_REV);
        chk("rev", 32'(`TW_REV_CODE), rd);
        wr(2'h0, `TW_ADDR_REV, 32'hFF);
        rdb(2'h0, `TW_ADDR_REV);
        chk("rev ro", 32'(`TW_REV_CODE), rd);
        $display("reset and revision test done");
    endtask : t_main
    task automatic t_pll;
        wr(2'h2, `TW_ADDR_LOOP, 32'h0003036F);
        chk("pll", 32'({5'h0F, 3'h3, 3'h3, 2'h3}),
            32'({cfg.loop_bw, cfg.pll_bias, cfg.vco_ctrl, cfg.vco_drive}));
        rdb(2'h3, `TW_ADDR_LOOP);
        chk("pll rd", 32'h0003036F, rd);
        wr(2'h0, `TW_ADDR_DCLK, 32'h2);
        chk("dly", 32'h1, 32'(cfg.delay_msb));
        $display("pll test done");
    endtask : t_pll
    task automatic t_port;
        // first byte turns on lsb-first, second byte must follow it to 0x01
        u_host.flip = 1'h1;
        wr(2'h1, `TW_ADDR_COMM, 32'h0240);
        u_host.flip = 1'h0;
        chk("flip lsb", 32'h1, 32'(cfg.lsb_first));
        chk("flip dly", 32'h1, 32'(cfg.delay_msb));
        rdb(2'h0, `TW_ADDR_DCLK);
        chk("flip rd", 32'h2, rd);
        wr(2'h0, `TW_ADDR_COMM, 32'h40);
        chk("lsb", 32'h1, 32'(cfg.lsb_first));
        u_host.lsb = 1'h1;
        rdb(2'h1, `TW_ADDR_BIAS);
        chk("lsb rd", 32'h6F03, rd);
        wr(2'h0, `TW_ADDR_COMM, 32'h80);
        u_host.lsb = 1'h0;
        u_host.bidir = 1'h1;
        chk("bidir", 32'h1, 32'(cfg.sdio_bidir));
        rdb(2'h0, `TW_ADDR_REV);
        chk("bidir rd", 32'(`TW_REV_CODE), rd);
        wr(2'h0, `TW_ADDR_COMM, 32'hB8);
        chk("comm bits", 32'h7, 32'({cfg.soft_reset, cfg.power_down, cfg.auto_pd}));
        wr(2'h0, `TW_ADDR_COMM, 32'h0);
        u_host.bidir = 1'h0;
        chk("comm cfg", 32'h0, 32'({cfg.sdio_bidir, cfg.lsb_first}));
        $display("port mode test done");
    endtask : t_port
    task automatic t_abort;
        u_host.cut = 12;
        wr(2'h0, `TW_ADDR_DCLK, 32'hFF);
        u_host.cut = 0;
        rdb(2'h0, `TW_ADDR_DCLK);
        chk("abort", 32'h2, rd);
        $display("abort test done");
    endtask : t_abort
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'h1;
        @(negedge clk);
        t_main();
        t_pll();
        t_port();
        t_abort();
        finish_test();
    end
endmodule : tw_port_tb
